// ---- irq_pkg.sv ----
// constants and carriers shared by the interrupt request logic
// assumes a 32-bit apb slave port and a single 200 mhz system clock
package irq_pkg;
    localparam int CLK_MHZ = 200;
    localparam int NUM_EXT = 2;
    localparam int NUM_GRP = 4;
    localparam int NUM_SRC = 8;
    localparam int NUM_VEC = 8;
    localparam int VEC_W = 3;
    localparam int ADDR_W = 12;

    // register byte offsets
    localparam logic [11:0] CTRL_OFS = 12'h000;
    localparam logic [11:0] FLAG_OFS = 12'h004;
    localparam logic [11:0] EDGE_OFS = 12'h008;
    localparam logic [11:0] SRC_OFS = 12'h00c;
    localparam logic [11:0] TICK_OFS = 12'h010;
    localparam logic [11:0] STAT_OFS = 12'h014;

    // vector numbers, lower number wins on simultaneous requests
    localparam logic [2:0] VEC_EXT0 = 3'h0;
    localparam logic [2:0] VEC_EXT1 = 3'h1;
    localparam logic [2:0] VEC_CONV = 3'h2;
    localparam logic [2:0] VEC_SERIAL = 3'h3;
    localparam logic [2:0] VEC_GRP0 = 3'h4;

    // field positions
    localparam int SRC_EN_POS = 8;
    localparam int TICK0_SEL_POS = 0;
    localparam int TICK1_SEL_POS = 4;
    localparam int TICK_ON_POS = 7;
    localparam int STAT_VEC_POS = 4;

    // edge select codes, two bits per pin
    localparam logic [1:0] EDGE_OFF = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

    // reset values, tick field mask and divider constants
    localparam logic [10:0] CTRL_RST = 11'h000;
    localparam logic [7:0] TICK_RST = 8'h00;
    localparam logic [7:0] TICK_MASK = 8'hb7;
    localparam logic [14:0] TICK_FULL = 15'h7fff;
    localparam logic [2:0] TICK0_SHIFT = 3'h7;
    localparam logic [1:0] TICK1_SHIFT = 2'h3;

    typedef struct packed {
        logic [1:0] pull_up;
        logic [3:0] grp_en;
        logic serial_en;
        logic conv_en;
        logic [1:0] ext_en;
        logic gie;
    } ctrl_s;

    typedef struct packed {
        logic [3:0] grp;
        logic serial;
        logic conv;
        logic [1:0] ext;
    } pend_s;
endpackage

// ---- irq_source_request_logic.sv ----
// interrupt request flags, enables and service clearing for one mcu core
// assumes apb master on clk_i, cpu sequencer gives stack_full_i and ack pulses
//
// Operation
// - a pin's chosen transition sets that pin's external request flag
// - external branch needs global enable and that pin's own enable
// - edge select offers rising, falling or both edges
// - edge select code off keeps the pin from setting its flag
// - vector call needs enable, stack not full and the transition seen
// - servicing an external request clears its flag and global enable
// - pin pull-up choice stays active while used as interrupt
// - four grouped interrupts built from timer, voltage, eeprom, tick
// - group flag sets whenever an included enabled source flag sets
// - servicing a group clears its flag and the global enable
// - conversion finish sets converter-done flag
// - converter branch needs global and converter enable, stack not full
// - servicing converter request clears its flag and global enable
// - serial port low pulse on any of its conditions sets serial flag
// - serial branch gated by enables and stack; service clears flag, gie
// - serial port status flags are untouched by servicing
// - each tick flag sets on its divider overflow
// - tick branch needs global, tick and group enable, stack not full
// - each tick period comes from dividing tick clock by a chosen ratio
// - while stack full no request is taken; it stays pending
// - any request flag set wakes the device from low power
// - second tick period is 4096, 8192, 16384 or 32768 tick clocks
//
// Implementation choices: the address map and the APB register port.
`timescale 1ns/1ps
module irq_source_request_logic
    import irq_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic [NUM_EXT-1:0] ext_irq_pin_i,
    input wire logic tick_clock_i,
    input wire logic [3:0] tm_req_i,
    input wire logic lvd_req_i,
    input wire logic eeprom_req_i,
    input wire logic conv_done_i,
    input wire logic serial_irq_n_i,
    input wire logic stack_full_i,
    input wire logic irq_ack_i,
    input wire logic [VEC_W-1:0] ack_vec_i,
    output logic irq_req_o,
    output logic [VEC_W-1:0] irq_vec_o,
    output logic global_irq_enable_o,
    output logic wake_o,
    output logic [NUM_EXT-1:0] pull_up_o
);
    ctrl_s ctrl_r;
    pend_s pend_r;
    logic [2*NUM_EXT-1:0] edge_select_reg_r;
    logic [NUM_SRC-1:0] src_flag_r;
    logic [NUM_SRC-1:0] src_en_r;
    logic [7:0] tick_control_reg_r;
    logic [NUM_EXT-1:0] pin_s1_r, pin_s2_r, pin_d_r;
    logic tick_s1_r, tick_s2_r, tick_d_r;
    logic [14:0] tick_cnt_r;
    logic serial_d_r;
    logic wake_r;
    logic [31:0] prdata_r;

    logic wr_en;
    logic setup;
    logic mapped;
    logic [NUM_EXT-1:0] pin_rise, pin_fall, ext_set;
    logic serial_set;
    logic tick_edge, tick0_ovf, tick1_ovf;
    logic [14:0] tick0_mask, tick1_mask;
    logic [NUM_SRC-1:0] src_set;
    logic [NUM_GRP-1:0] grp_set;
    logic [NUM_VEC-1:0] pend_set, pend_clr, pend_ack, pend_en, live;
    logic [31:0] rdata_nxt;
    logic [VEC_W-1:0] vec_nxt;

    assign setup = psel_i && !penable_i;
    assign wr_en = psel_i && penable_i && pwrite_i;
    assign mapped = (paddr_i == CTRL_OFS) || (paddr_i == FLAG_OFS)
        || (paddr_i == EDGE_OFS) || (paddr_i == SRC_OFS)
        || (paddr_i == TICK_OFS) || (paddr_i == STAT_OFS);
    // zero wait state slave; read data captured in the setup cycle
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i && penable_i && !mapped;
    assign prdata_o = prdata_r;

    // pins come from outside, first stage feeds only the second
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_s1_r <= '0;
            pin_s2_r <= '0;
            pin_d_r <= '0;
        end else begin
            pin_s1_r <= ext_irq_pin_i;
            pin_s2_r <= pin_s1_r;
            pin_d_r <= pin_s2_r;
        end
    end

    assign pin_rise = pin_s2_r & ~pin_d_r;
    assign pin_fall = ~pin_s2_r & pin_d_r;

    always_comb begin
        for (int i = 0; i < NUM_EXT; i++) begin
            case (edge_select_reg_r[2*i +: 2])
                EDGE_RISE: ext_set[i] = pin_rise[i];
                EDGE_FALL: ext_set[i] = pin_fall[i];
                EDGE_BOTH: ext_set[i] = pin_rise[i] | pin_fall[i];
                default: ext_set[i] = 1'b0;
            endcase
        end
    end

    // serial port pulses low; only the leading edge counts so a long
    // pulse does not re-set the flag after it was serviced
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            serial_d_r <= 1'b1;
        end else begin
            serial_d_r <= serial_irq_n_i;
        end
    end

    assign serial_set = serial_d_r && !serial_irq_n_i;

    // tick clock is a pin-level clock sampled as data
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tick_s1_r <= 1'b0;
            tick_s2_r <= 1'b0;
            tick_d_r <= 1'b0;
        end else begin
            tick_s1_r <= tick_clock_i;
            tick_s2_r <= tick_s1_r;
            tick_d_r <= tick_s2_r;
        end
    end

    assign tick_edge = tick_s2_r && !tick_d_r && tick_control_reg_r[TICK_ON_POS];

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tick_cnt_r <= '0;
        end else if (tick_edge) begin
            tick_cnt_r <= tick_cnt_r + 15'h0001;
        end
    end

    // period 256 << sel for tick0, 4096 << sel for tick1
    assign tick0_mask = TICK_FULL >> (TICK0_SHIFT - tick_control_reg_r[TICK0_SEL_POS +: 3]);
    assign tick1_mask = TICK_FULL >> (TICK1_SHIFT - tick_control_reg_r[TICK1_SEL_POS +: 2]);
    assign tick0_ovf = tick_edge && ((tick_cnt_r & tick0_mask) == tick0_mask);
    assign tick1_ovf = tick_edge && ((tick_cnt_r & tick1_mask) == tick1_mask);

    assign src_set = {tick1_ovf, tick0_ovf, eeprom_req_i, lvd_req_i, tm_req_i};

    // source flags stay until software clears them
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            src_flag_r <= '0;
            src_en_r <= '0;
        end else begin
            if (wr_en && paddr_i == SRC_OFS) begin
                src_en_r <= pwdata_i[SRC_EN_POS +: NUM_SRC];
                src_flag_r <= (src_flag_r & ~pwdata_i[NUM_SRC-1:0]) | src_set;
            end else begin
                src_flag_r <= src_flag_r | src_set;
            end
        end
    end

    // group g gathers sources 2g and 2g+1
    always_comb begin
        for (int g = 0; g < NUM_GRP; g++) begin
            grp_set[g] = |(src_set[2*g +: 2] & src_en_r[2*g +: 2]);
        end
    end

    assign pend_set = {grp_set, serial_set, conv_done_i, ext_set};
    assign pend_ack = irq_ack_i ? (NUM_VEC'(1) << ack_vec_i) : '0;
    assign pend_clr = pend_ack
        | ((wr_en && paddr_i == FLAG_OFS) ? pwdata_i[NUM_VEC-1:0] : '0);

    // a set in the clearing cycle wins; servicing never touches sources
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pend_r <= '0;
        end else begin
            pend_r <= (pend_r & ~pend_clr) | pend_set;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_r <= CTRL_RST;
        end else begin
            if (wr_en && paddr_i == CTRL_OFS) begin
                ctrl_r <= pwdata_i[10:0];
            end
            if (irq_ack_i) begin
                ctrl_r.gie <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            edge_select_reg_r <= '0;
            tick_control_reg_r <= TICK_RST;
        end else begin
            if (wr_en && paddr_i == EDGE_OFS) begin
                edge_select_reg_r <= pwdata_i[2*NUM_EXT-1:0];
            end
            if (wr_en && paddr_i == TICK_OFS) begin
                tick_control_reg_r <= pwdata_i[7:0] & TICK_MASK;
            end
        end
    end

    assign pull_up_o = ctrl_r.pull_up;
    assign global_irq_enable_o = ctrl_r.gie;

    // pending flag stays set while stack is full, request just waits
    assign pend_en = {ctrl_r.grp_en, ctrl_r.serial_en, ctrl_r.conv_en, ctrl_r.ext_en};
    assign live = pend_r & pend_en;
    assign irq_req_o = ctrl_r.gie && !stack_full_i && (|live);

    always_comb begin
        vec_nxt = '0;
        for (int v = NUM_VEC - 1; v >= 0; v--) begin
            if (live[v]) begin
                vec_nxt = VEC_W'(v);
            end
        end
    end

    assign irq_vec_o = vec_nxt;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wake_r <= 1'b0;
        end else begin
            wake_r <= (|pend_r) || (|src_flag_r);
        end
    end

    assign wake_o = wake_r;

    always_comb begin
        rdata_nxt = '0;
        case (paddr_i)
            CTRL_OFS: rdata_nxt[10:0] = ctrl_r;
            FLAG_OFS: rdata_nxt[NUM_VEC-1:0] = pend_r;
            EDGE_OFS: rdata_nxt[2*NUM_EXT-1:0] = edge_select_reg_r;
            SRC_OFS: rdata_nxt[15:0] = {src_en_r, src_flag_r};
            TICK_OFS: rdata_nxt[7:0] = tick_control_reg_r;
            STAT_OFS: rdata_nxt[7:0] = {1'b0, vec_nxt, stack_full_i, irq_req_o, pin_s2_r};
            default: rdata_nxt = '0;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prdata_r <= '0;
        end else if (setup && !pwrite_i) begin
            prdata_r <= rdata_nxt;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    a_req_gate_enable: assert property (
        irq_req_o |-> pend_r[irq_vec_o] && pend_en[irq_vec_o] && !stack_full_i)
        else $error("request without pending enabled vector");

    a_gie_off_quiet: assert property (
        !ctrl_r.gie |-> !irq_req_o)
        else $error("request while global enable off");

    a_stack_full_block: assert property (
        stack_full_i |-> !irq_req_o)
        else $error("request taken while stack full");

    // a full stack only delays service, so no pending flag may drop
    a_stack_full_keep: assert property (
        stack_full_i && !irq_ack_i && !(wr_en && paddr_i == FLAG_OFS)
        |=> (~pend_r & $past(pend_r)) == 8'h00)
        else $error("pending flag lost while stack full");

    a_vec_lowest: assert property (
        irq_req_o && live[0] |-> irq_vec_o == VEC_EXT0)
        else $error("pin 0 request lost priority");

    a_ext_rise_set: assert property (
        pin_rise[0] && edge_select_reg_r[1:0] == EDGE_RISE |=> pend_r.ext[0])
        else $error("rising edge did not set flag");

    a_edge_off_quiet: assert property (
        edge_select_reg_r[1:0] == EDGE_OFF && !pend_r.ext[0]
        && !(wr_en && paddr_i == FLAG_OFS) |=> !pend_r.ext[0])
        else $error("disabled pin set its flag");

    a_edge_fall_set: assert property (
        pin_fall[0] && edge_select_reg_r[1:0] == EDGE_FALL |=> pend_r.ext[0])
        else $error("falling edge did not set flag");

    a_ack_clears_gie: assert property (
        irq_ack_i |=> !ctrl_r.gie)
        else $error("service did not clear gie");

    // a new event on the serviced vector in the same cycle keeps it set
    a_ack_clears_flag: assert property (
        irq_ack_i |=> !pend_r[$past(ack_vec_i)] || $past(pend_set[ack_vec_i]))
        else $error("service did not clear flag");

    a_conv_done_set: assert property (
        conv_done_i |=> pend_r.conv)
        else $error("conversion end not flagged");

    a_serial_pulse_set: assert property (
        $fell(serial_irq_n_i) |-> ##1 pend_r.serial)
        else $error("serial pulse not flagged");

    a_group_tick_set: assert property (
        tick1_ovf && src_en_r[7] |=> pend_r.grp[3] && src_flag_r[7])
        else $error("tick overflow not flagged in group");

    a_group_src_enable: assert property (
        src_set[0] && src_en_r[0] |=> pend_r.grp[0])
        else $error("timer source not flagged in group");

    a_ack_keeps_src: assert property (
        irq_ack_i && src_flag_r[4] && !(wr_en && paddr_i == SRC_OFS) |=> src_flag_r[4])
        else $error("servicing cleared a source flag");

    a_wake_on_flag: assert property (
        $rose(|pend_r) |=> wake_o)
        else $error("flag did not wake device");
endmodule

// ---- cpu_seq_model.sv ----
// behavioural cpu sequencer that services the request logic's vectors
// assumes irq_req_o and irq_vec_o of the request logic on the same clock
`timescale 1ns/1ps
module cpu_seq_model (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic auto_ack_i,
    input wire logic [3:0] ack_delay_i,
    input wire logic irq_req_i,
    input wire logic [2:0] irq_vec_i,
    output logic irq_ack_o,
    output logic [2:0] ack_vec_o
);
    logic [3:0] wait_r;
    // the vector bus carries junk outside an ack, so nothing may rely on it
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wait_r <= 4'h0;
            irq_ack_o <= 1'b0;
            ack_vec_o <= 3'h0;
        end else begin
            irq_ack_o <= 1'b0;
            ack_vec_o <= ~ack_vec_o;
            if (!auto_ack_i || !irq_req_i || irq_ack_o) begin
                wait_r <= 4'h0;
            end else if (wait_r == ack_delay_i) begin
                irq_ack_o <= 1'b1;
                ack_vec_o <= irq_vec_i;
                wait_r <= 4'h0;
            end else begin
                wait_r <= wait_r + 4'h1;
            end
        end
    end
endmodule

// ---- irq_source_request_logic_tb.sv ----
// self-checking bench for the interrupt request logic over apb
// assumes cpu_seq_model services vectors; pins and peripherals driven here
`timescale 1ns/1ps
module irq_source_request_logic_tb;
    import irq_pkg::*;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, tick_clk = 1'b0, lvd = 1'b0, conv = 1'b0, ser_n = 1'b1;
    logic stack_full = 1'b0, ack, auto_ack = 1'b0, req, gie, wake;
    logic [1:0] pins = 2'h0, pull_up;
    logic [2:0] ack_vec, vec;
    logic [3:0] ack_delay = 4'h0;
    logic [3:0] tm = 4'h0;
    logic ee = 1'b0;
    int miscompares = 0, samples_checked = 0, cycles = 0;

    always #2.5 clk_i = ~clk_i;

    irq_source_request_logic u_irq_source_request_logic (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .ext_irq_pin_i(pins), .tick_clock_i(tick_clk), .tm_req_i(tm), .lvd_req_i(lvd),
        .eeprom_req_i(ee), .conv_done_i(conv), .serial_irq_n_i(ser_n),
        .stack_full_i(stack_full), .irq_ack_i(ack), .ack_vec_i(ack_vec), .irq_req_o(req),
        .irq_vec_o(vec), .global_irq_enable_o(gie), .wake_o(wake), .pull_up_o(pull_up));

    cpu_seq_model u_cpu_seq_model (.clk_i(clk_i), .rst_n_i(rst_n_i), .auto_ack_i(auto_ack),
        .ack_delay_i(ack_delay), .irq_req_i(req), .irq_vec_i(vec), .irq_ack_o(ack),
        .ack_vec_o(ack_vec));

    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // a hang in any wait ends the run as a failure
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            miscompares = miscompares + 1;
            final_report();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic err);
        @(posedge clk_i);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        @(posedge clk_i);
        while (pready !== 1'b1) @(posedge clk_i);
        rd = prdata;
        chk({31'h0, pslverr}, {31'h0, err});
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 1'b0);
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, 1'b0);
        chk(rd, exp);
    endtask

    // request and vector packed as {req, vec}, sampled once the edge settles
    task automatic look(input logic [3:0] exp);
        cyc(1);
        #1;
        chk({28'h0, req, vec}, {28'h0, exp});
    endtask

    initial begin
        cyc(20);
        rst_n_i <= 1'b1;
        rdc(CTRL_OFS, 32'h0);
        rdc(TICK_OFS, 32'h0);
        rdc(FLAG_OFS, 32'h0);
        apb(1'b0, 12'h020, 32'h0, 1'b1);
        chk(rd, 32'h0);
        wr(CTRL_OFS, 32'h600);
        rdc(CTRL_OFS, 32'h600);
        chk({30'h0, pull_up}, 32'h3);
        for (int i = 0; i < 4; i++) begin
            wr(EDGE_OFS, i);
            wr(FLAG_OFS, 32'hff);
            pins <= 2'h1;
            cyc(4);
            rdc(FLAG_OFS, {31'h0, EDGE_RISE[0] & i[0]});
            wr(FLAG_OFS, 32'hff);
            pins <= 2'h0;
            cyc(4);
            rdc(FLAG_OFS, {31'h0, EDGE_FALL[1] & i[1]});
        end
        wr(CTRL_OFS, 32'h1);
        look({1'b0, VEC_EXT0});
        wr(CTRL_OFS, 32'h3);
        look({1'b1, VEC_EXT0});
        chk({31'h0, gie}, 32'h1);
        cyc(1);
        auto_ack <= 1'b1;
        cyc(8);
        rdc(FLAG_OFS, 32'h0);
        rdc(CTRL_OFS, 32'h2);
        chk({31'h0, gie}, 32'h0);
        auto_ack <= 1'b0;
        wr(CTRL_OFS, 32'h9);
        stack_full <= 1'b1;
        conv <= 1'b1;
        cyc(1);
        conv <= 1'b0;
        cyc(2);
        look({1'b0, VEC_CONV});
        chk({31'h0, wake}, 32'h1);
        rdc(STAT_OFS, 32'h28);
        cyc(1);
        stack_full <= 1'b0;
        look({1'b1, VEC_CONV});
        cyc(1);
        ack_delay <= 4'h5;
        auto_ack <= 1'b1;
        cyc(12);
        rdc(FLAG_OFS, 32'h0);
        rdc(CTRL_OFS, 32'h8);
        wr(CTRL_OFS, 32'h10);
        ser_n <= 1'b0;
        cyc(1);
        ser_n <= 1'b1;
        cyc(3);
        rdc(FLAG_OFS, 32'h8);
        wr(CTRL_OFS, 32'h11);
        cyc(12);
        rdc(FLAG_OFS, 32'h0);
        rdc(CTRL_OFS, 32'h10);
        // tm0 and eeprom enabled, tm3 not: only groups 0 and 2 may set
        wr(SRC_OFS, 32'h2100);
        tm <= 4'h9;
        ee <= 1'b1;
        cyc(1);
        tm <= 4'h0;
        ee <= 1'b0;
        cyc(1);
        rdc(SRC_OFS, 32'h2129);
        rdc(FLAG_OFS, 32'h50);
        wr(SRC_OFS, 32'h00ff);
        wr(FLAG_OFS, 32'h50);
        rdc(SRC_OFS, 32'h0);
        rdc(FLAG_OFS, 32'h0);
        wr(SRC_OFS, 32'h1000);
        lvd <= 1'b1;
        cyc(1);
        lvd <= 1'b0;
        cyc(3);
        rdc(FLAG_OFS, 32'h40);
        wr(CTRL_OFS, 32'h81);
        cyc(12);
        rdc(FLAG_OFS, 32'h0);
        rdc(SRC_OFS, 32'h1010);
        wr(SRC_OFS, 32'h1010);
        rdc(SRC_OFS, 32'h1000);
        wr(SRC_OFS, 32'h4000);
        wr(TICK_OFS, 32'h80);
        rdc(TICK_OFS, 32'h80);
        // tick0 overflows on edge 255, tick1 on edge 4095
        for (int t = 0; t < 4100; t++) begin
            if (t == 250) begin
                rdc(SRC_OFS, 32'h4000);
            end
            if (t == 262) begin
                rdc(SRC_OFS, 32'h4040);
                rdc(FLAG_OFS, 32'h80);
                wr(SRC_OFS, 32'h8040);
                wr(FLAG_OFS, 32'h80);
                rdc(SRC_OFS, 32'h8000);
            end
            if (t == 4090) begin
                rdc(SRC_OFS, 32'h8040);
                rdc(FLAG_OFS, 32'h0);
            end
            cyc(3);
            tick_clk <= 1'b1;
            cyc(3);
            tick_clk <= 1'b0;
        end
        cyc(6);
        rdc(SRC_OFS, 32'h80c0);
        rdc(FLAG_OFS, 32'h80);
        wr(SRC_OFS, 32'h80c0);
        rdc(SRC_OFS, 32'h8000);
        final_report();
    end
endmodule
